// *** rtl/urx_pkg.sv ***
// constants shared by the serial receiver and the remote transmitter
//============================================================
// Notes on behaviour
// - words of 8 or 9 bits; ninth bit readable
// - 16x oversampling; one shift per bit time
// - each bit decided by three-sample majority
// - after stop sample, move word into buffer
// - lsb first; shift register hidden from software
// - four-entry fifo; fifth word keeps assembling
// - enable bit starts the start-bit search
// - data-available flag and readable fill count
// - trigger-level fill raises interrupt when enabled
// - status access then data read clears available
// - long low: word length plus stop, then done
// - break: framing, zero word, idle; interrupt only if trigger fill reached or fifo already full
// - after break wait for high before start
// - idle low from start until stop bit
// - full fifo: overrun set, contents kept
// - overrun also raises interrupt when enabled
// - overrun cleared by status then data read
// - noise flag set with word, no interrupt
// - noise cleared by status then data read
// - receiver checks exactly one stop bit
// - low stop sample sets framing flag with word
// - odd or even parity mismatch sets flag
package urx_pkg;
  // register addresses
  localparam logic [2:0] ADDR_STATUS = 3'h0;
  localparam logic [2:0] ADDR_CTRL1 = 3'h1;
  localparam logic [2:0] ADDR_CTRL2 = 3'h2;
  localparam logic [2:0] ADDR_BAUD_HI = 3'h3;
  localparam logic [2:0] ADDR_BAUD_LO = 3'h4;
  localparam logic [2:0] ADDR_DATA = 3'h5;
  localparam logic [2:0] ADDR_COUNT = 3'h6;
  // status bit positions
  localparam int ST_PARITY = 0;
  localparam int ST_NOISE = 1;
  localparam int ST_FRAMING = 2;
  localparam int ST_OVERRUN = 3;
  localparam int ST_IDLE = 4;
  localparam int ST_AVAIL = 5;
  // control one bit positions
  localparam int C1_NINTH = 0;
  localparam int C1_WLEN = 1;
  localparam int C1_PAREN = 2;
  localparam int C1_PTYPE = 3;
  // control two bit positions
  localparam int C2_RXEN = 0;
  localparam int C2_IRQEN = 1;
  localparam int C2_TRIG = 2;
  // reset values
  localparam logic [7:0] CTRL1_RST = 8'h00;
  localparam logic [7:0] CTRL2_RST = 8'h00;
  localparam logic [15:0] BAUD_RST = 16'h0035;
  // parity types
  localparam logic [1:0] PAR_EVEN = 2'h0;
  localparam logic [1:0] PAR_ODD = 2'h1;
  localparam logic [1:0] PAR_MARK = 2'h2;
  // timing
  localparam int OVERSAMPLE = 16;
  localparam logic [3:0] SAMPLE_FIRST = 4'h7;
  localparam logic [3:0] SAMPLE_LAST = 4'h9;
  localparam logic [3:0] PHASE_LAST = 4'hF;
  localparam int FIFO_DEPTH = 4;
  localparam logic [4:0] BREAK_FRAME_BITS = 5'h0F;
  // fifo entry layout: {parity, noise, framing, word[8:0]}
  localparam int WORD_W = 9;
  localparam int ENTRY_W = 12;
  localparam int EN_FRAMING = 9;
  localparam int EN_NOISE = 10;
  localparam int EN_PARITY = 11;
  typedef enum logic [4:0] {
    RX_IDLE = 5'b00001,
    RX_START = 5'b00010,
    RX_DATA = 5'b00100,
    RX_STOP = 5'b01000,
    RX_WAIT_HIGH = 5'b10000
  } urx_state_t;
endpackage

// *** rtl/urx_if.sv ***
// receive line between the remote transmitter and the receiver
`timescale 1ns/1ns
interface urx_if;
  logic line;
  modport dev (input line);
  modport far (output line);
endinterface

// *** rtl/urx_far_tx.sv ***
// remote asynchronous transmitter driving the receive line
`timescale 1ns/1ns
module urx_far_tx
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // user side
  input wire logic send,
  input wire logic send_break,
  input wire logic [8:0] tx_data,
  input wire logic word_length_sel,
  input wire logic parity_enable_bit,
  input wire logic [1:0] parity_type_sel,
  input wire logic [15:0] baud_div,
  output logic busy,
  // serial link
  urx_if.far link
);
  import urx_pkg::*;

  logic line_q;
  logic [15:0] tick_cnt;
  logic tick;
  logic [3:0] phase;
  logic [14:0] sr;
  logic [4:0] left;
  logic [8:0] lower;
  logic par;
  logic [8:0] payload;

  assign link.line = line_q;
  assign tick = busy && (tick_cnt == baud_div);

  //============================================================
  // frame build
  always_comb
  begin
    lower = word_length_sel ? {1'b0, tx_data[7:0]} : {2'b00, tx_data[6:0]};
    unique case (parity_type_sel)
      PAR_EVEN: par = ^lower;
      PAR_ODD: par = ~^lower;
      PAR_MARK: par = 1'b1;
      default: par = 1'b0;
    endcase
    payload = tx_data;
    if (parity_enable_bit)
    begin
      if (word_length_sel)
        payload[8] = par;
      else
        payload[7] = par;
    end
  end

  //============================================================
  // oversample tick
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      tick_cnt <= 16'h0000;
    else if (ce)
      tick_cnt <= (!busy || tick) ? 16'h0000 : tick_cnt + 16'h0001;
  end

  //============================================================
  // shifter, lsb first after the start bit
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      line_q <= 1'b1;
      busy <= 1'b0;
      phase <= 4'h0;
      sr <= 15'h7FFF;
      left <= 5'h00;
    end
    else if (ce)
    begin
      if (!busy)
      begin
        if (send || send_break)
        begin
          busy <= 1'b1;
          line_q <= 1'b0;
          phase <= 4'h0;
          if (send_break)
          begin
            sr <= 15'h2000;
            left <= BREAK_FRAME_BITS - 5'h01;
          end
          else if (word_length_sel)
          begin
            sr <= {5'h1F, 1'b1, payload};
            left <= 5'h0A;
          end
          else
          begin
            sr <= {6'h3F, 1'b1, payload[7:0]};
            left <= 5'h09;
          end
        end
      end
      else if (tick)
      begin
        phase <= phase + 4'h1;
        if (phase == PHASE_LAST)
        begin
          if (left == 5'h00)
            busy <= 1'b0;
          else
          begin
            line_q <= sr[0];
            sr <= {1'b1, sr[14:1]};
            left <= left - 5'h01;
          end
        end
      end
    end
  end
endmodule

// *** rtl/urx_receiver.sv ***
// serial receiver with oversampled recovery and four-entry fifo
//
// Local design decisions: the plain strobed port and the address map.
`timescale 1ns/1ns
module urx_receiver
#(
  parameter int DEPTH = urx_pkg::FIFO_DEPTH
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // register port
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // interrupt request
  output logic rx_irq,
  // serial link
  urx_if.dev link
);
  import urx_pkg::*;

  localparam int PTR_W = $clog2(DEPTH);

  generate
    if (DEPTH != 2 && DEPTH != 4)
    begin : g_bad_depth
      $error("depth must be 2 or 4");
    end
  endgenerate

  logic sync_a;
  logic sync_b;
  logic [7:0] ctrl1;
  logic [7:0] ctrl2;
  logic [15:0] baud_div;
  logic [15:0] tick_cnt;
  logic tick;
  urx_state_t state;
  logic [3:0] phase;
  logic [1:0] samp;
  logic [2:0] vote;
  logic maj;
  logic decide;
  logic [3:0] bit_idx;
  logic [WORD_W-1:0] shift;
  logic noise_seen;
  logic rx_idle_flag;
  logic done;
  logic [ENTRY_W-1:0] done_entry;
  logic [ENTRY_W-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [PTR_W:0] rx_fill_count;
  logic full;
  logic push;
  logic pop;
  logic armed;
  logic overrun_flag;
  logic ovr_event;
  logic [ENTRY_W-1:0] head;
  logic rx_data_avail_flag;
  logic rx_enable_bit;
  logic rx_irq_enable;
  logic word_length_sel;
  logic [WORD_W-1:0] word;
  logic frm;
  logic perr;
  logic [PTR_W:0] trig;

  assign rx_enable_bit = ctrl2[C2_RXEN];
  assign rx_irq_enable = ctrl2[C2_IRQEN];
  assign word_length_sel = ctrl1[C1_WLEN];

  //============================================================
  // line synchroniser
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sync_a <= 1'b1;
      sync_b <= 1'b1;
    end
    else if (ce)
    begin
      sync_a <= link.line;
      sync_b <= sync_a;
    end
  end

  //============================================================
  // oversample tick, sixteen per bit
  assign tick = rx_enable_bit && (tick_cnt == baud_div);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      tick_cnt <= 16'h0000;
    else if (ce)
      tick_cnt <= (!rx_enable_bit || tick) ? 16'h0000 : tick_cnt + 16'h0001;
  end

  //============================================================
  // majority vote
  assign vote = {samp, sync_b};
  assign maj = (vote[0] & vote[1]) | (vote[0] & vote[2]) | (vote[1] & vote[2]);
  assign decide = tick && (phase == SAMPLE_LAST);

  always_comb
  begin
    word = word_length_sel ? shift : {1'b0, shift[8:1]};
    frm = !maj;
    perr = 1'b0;
    if (ctrl1[C1_PAREN] && ctrl1[C1_PTYPE+1] == 1'b0)
      perr = (^word) != (ctrl1[C1_PTYPE+:2] == PAR_ODD);
  end

  //============================================================
  // frame state machine
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state <= RX_IDLE;
      phase <= 4'h0;
      samp <= 2'b11;
      bit_idx <= 4'h0;
      shift <= '0;
      noise_seen <= 1'b0;
      rx_idle_flag <= 1'b1;
      done <= 1'b0;
      done_entry <= '0;
    end
    else if (ce)
    begin
      done <= 1'b0;
      if (!rx_enable_bit)
      begin
        state <= RX_IDLE;
        rx_idle_flag <= 1'b1;
        phase <= 4'h0;
      end
      else if (tick)
      begin
        phase <= (state == RX_IDLE) ? 4'h1 : phase + 4'h1;
        if (phase >= SAMPLE_FIRST && phase < SAMPLE_LAST)
          samp <= {samp[0], sync_b};
        unique case (state)
          RX_IDLE:
            if (!sync_b)
            begin
              state <= RX_START;
              rx_idle_flag <= 1'b0;
              noise_seen <= 1'b0;
            end
          RX_START:
            if (decide)
            begin
              noise_seen <= !(&vote) && (|vote);
              bit_idx <= 4'h0;
              if (maj)
              begin
                state <= RX_IDLE;
                rx_idle_flag <= 1'b1;
              end
              else
                state <= RX_DATA;
            end
          RX_DATA:
            if (decide)
            begin
              shift <= {maj, shift[WORD_W-1:1]};
              if (!(&vote) && (|vote))
                noise_seen <= 1'b1;
              bit_idx <= bit_idx + 4'h1; // phase wraps, next decision 16 ticks on
              if (bit_idx == (word_length_sel ? 4'h8 : 4'h7))
                state <= RX_STOP;
            end
          RX_STOP:
            if (decide)
            begin
              rx_idle_flag <= 1'b1;
              done <= 1'b1;
              done_entry <= {perr, noise_seen | (!(&vote) && (|vote)), frm, word};
              state <= frm ? RX_WAIT_HIGH : RX_IDLE;
            end
          RX_WAIT_HIGH:
            if (sync_b)
              state <= RX_IDLE;
          default:
            state <= RX_IDLE;
        endcase
      end
    end
  end

  //============================================================
  // receive fifo
  assign full = (rx_fill_count == (PTR_W + 1)'(DEPTH));
  assign push = done && !full;
  assign ovr_event = done && full;
  assign pop = rd && (addr == ADDR_DATA) && armed && (rx_fill_count != '0);
  assign head = (rx_fill_count != '0) ? mem[rd_ptr] : '0;
  assign rx_data_avail_flag = (rx_fill_count != '0);
  assign trig = (PTR_W + 1)'({1'b0, ctrl2[C2_TRIG+:2]} + 3'h1);

  always_ff @(posedge clk)
  begin
    if (ce && push)
      mem[wr_ptr] <= done_entry;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      rx_fill_count <= '0;
    end
    else if (ce)
    begin
      if (push)
        wr_ptr <= wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= rd_ptr + 1'b1;
      rx_fill_count <= rx_fill_count + (PTR_W + 1)'(push) - (PTR_W + 1)'(pop);
    end
  end

  //============================================================
  // clear sequence and overrun
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      armed <= 1'b0;
    else if (ce)
    begin
      if ((rd || wr) && addr == ADDR_STATUS)
        armed <= 1'b1;
      else if (rd && addr == ADDR_DATA)
        armed <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      overrun_flag <= 1'b0;
    else if (ce)
    begin
      if (ovr_event)
        overrun_flag <= 1'b1;
      else if (rd && addr == ADDR_DATA && armed)
        overrun_flag <= 1'b0;
    end
  end

  //============================================================
  // interrupt request
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rx_irq <= 1'b0;
    else if (ce)
      rx_irq <= rx_irq_enable && ((push && rx_fill_count + 1'b1 == trig) || ovr_event);
  end

  //============================================================
  // register writes
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl1 <= CTRL1_RST;
      ctrl2 <= CTRL2_RST;
      baud_div <= BAUD_RST;
    end
    else if (ce && wr)
    begin
      unique case (addr)
        ADDR_CTRL1: ctrl1 <= wdata;
        ADDR_CTRL2: ctrl2 <= wdata;
        ADDR_BAUD_HI: baud_div[15:8] <= wdata;
        ADDR_BAUD_LO: baud_div[7:0] <= wdata;
        default: ;
      endcase
    end
  end

  //============================================================
  // register reads, data one cycle later
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rdata <= 8'h00;
    else if (ce)
    begin
      if (rd)
      begin
        unique case (addr)
          ADDR_STATUS:
          begin
            rdata <= 8'h00;
            rdata[ST_PARITY] <= head[EN_PARITY];
            rdata[ST_NOISE] <= head[EN_NOISE];
            rdata[ST_FRAMING] <= head[EN_FRAMING];
            rdata[ST_OVERRUN] <= overrun_flag;
            rdata[ST_IDLE] <= rx_idle_flag;
            rdata[ST_AVAIL] <= rx_data_avail_flag;
          end
          ADDR_CTRL1: rdata <= {ctrl1[7:1], head[8]};
          ADDR_CTRL2: rdata <= ctrl2;
          ADDR_BAUD_HI: rdata <= baud_div[15:8];
          ADDR_BAUD_LO: rdata <= baud_div[7:0];
          ADDR_DATA: rdata <= head[7:0];
          ADDR_COUNT: rdata <= 8'(rx_fill_count);
          default: rdata <= 8'h00;
        endcase
      end
    end
  end
endmodule

// *** testbench/urx_properties.sv ***
// concurrent checks on the receive link and the register port
`timescale 1ns/1ns
module urx_properties
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // link and transmitter
  input wire logic line,
  input wire logic busy,
  // register port
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic rx_irq
);
  import urx_pkg::*;
  logic [7:0] ctrl2_q;
  //============================================================
  // control two shadow
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      ctrl2_q <= CTRL2_RST;
    else if (ce && wr && addr == ADDR_CTRL2)
      ctrl2_q <= wdata;
  end
  //============================================================
  // properties
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  property p_idle_high;
    !busy |-> line;
  endproperty
  property p_start_low;
    $rose(busy) |-> !line;
  endproperty
  property p_bit_hold;
    busy && $changed(line) |=> $stable(line) [*8];
  endproperty
  property p_frame_min;
    $rose(busy) |-> busy [*8];
  endproperty
  property p_irq_pulse;
    rx_irq |=> !rx_irq;
  endproperty
  property p_irq_enabled;
    rx_irq |-> $past(ctrl2_q[C2_IRQEN]);
  endproperty
  property p_rdata_hold;
    !$past(rd) |-> $stable(rdata);
  endproperty
  property p_unmapped;
    ce && rd && addr == 3'h7 |=> rdata == 8'h00;
  endproperty
  property p_count_max;
    ce && rd && addr == ADDR_COUNT |=> rdata <= FIFO_DEPTH;
  endproperty
  property p_ctrl2_read;
    ce && rd && addr == ADDR_CTRL2 |=> rdata == $past(ctrl2_q);
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("line low while idle");
  a_start_low: assert property (p_start_low) else $error("no start bit");
  a_bit_hold: assert property (p_bit_hold) else $error("bit too short");
  a_frame_min: assert property (p_frame_min) else $error("frame too short");
  a_irq_pulse: assert property (p_irq_pulse) else $error("irq not a pulse");
  a_irq_enabled: assert property (p_irq_enabled) else $error("irq while masked");
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_count_max: assert property (p_count_max) else $error("count above depth");
  a_ctrl2_read: assert property (p_ctrl2_read) else $error("control two readback");
  c_irq: cover property (rx_irq);
  c_frame: cover property ($rose(busy));
  c_data_read: cover property (rd && addr == ADDR_DATA);
endmodule

// *** testbench/tb_top.sv ***
// self-checking bench for the receiver and the remote transmitter
`timescale 1ns/1ns
module tb_top;
  import urx_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic rx_irq;
  logic send = 1'b0;
  logic send_break = 1'b0;
  logic [8:0] tx_data = 9'h000;
  logic wlen = 1'b0;
  logic paren = 1'b0;
  logic [1:0] ptype = 2'h0;
  logic busy;
  int bad_count = 0;
  int n_tests = 0;
  int irq_seen = 0;
  int cycles = 0;
  urx_if link_if();
  urx_far_tx urx_far_tx_inst (.clk(clk), .rst(rst), .ce(ce), .send(send),
    .send_break(send_break), .tx_data(tx_data), .word_length_sel(wlen),
    .parity_enable_bit(paren), .parity_type_sel(ptype), .baud_div(16'h0000),
    .busy(busy), .link(link_if.far));
  urx_receiver #(.DEPTH(FIFO_DEPTH)) urx_receiver_inst (.clk(clk), .rst(rst), .ce(ce),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .rx_irq(rx_irq),
    .link(link_if.dev));
  urx_properties urx_properties_inst (.clk(clk), .rst(rst), .ce(ce), .line(link_if.line),
    .busy(busy), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .rx_irq(rx_irq));
  //============================================================
  // clock, irq count, timeout
  always #5 clk = ~clk;
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (rx_irq === 1'b1)
      irq_seen <= irq_seen + 1;
    if (cycles == 20000)
    begin
      bad_count = bad_count + 1;
      conclude();
    end
  end
  //============================================================
  // reporting and bus tasks
  task automatic conclude();
    $display("counts: %0d checks, %0d mismatches", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic check8(string what, logic [7:0] exp, logic [7:0] seen);
    n_tests++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic check_n(string what, int exp, int seen);
    n_tests++;
    if (seen != exp)
    begin
      bad_count++;
      $display("mismatch %s expected %0d seen %0d", what, exp, seen);
    end
  endtask
  task automatic wr_reg(logic [2:0] a, logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic chk_reg(string what, logic [2:0] a, logic [7:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check8(what, exp, rdata);
  endtask
  function automatic logic [7:0] stat(logic av, logic ov, logic fr, logic pa);
    stat = 8'h00;
    stat[ST_AVAIL] = av;
    stat[ST_IDLE] = 1'b1;
    stat[ST_OVERRUN] = ov;
    stat[ST_FRAMING] = fr;
    stat[ST_PARITY] = pa;
  endfunction
  task automatic launch(logic [8:0] d, logic brk);
    @(posedge clk);
    tx_data <= d;
    send <= ~brk;
    send_break <= brk;
    @(posedge clk);
    send <= 1'b0;
    send_break <= 1'b0;
  endtask
  task automatic finish_frame();
    @(posedge clk);
    for (int n = 0; n < 5000 && busy !== 1'b0; n++)
      @(posedge clk);
    repeat (24) @(posedge clk);
  endtask
  task automatic frame(logic [8:0] d, logic brk);
    launch(d, brk);
    finish_frame();
  endtask
  //============================================================
  // scenarios
  task automatic t_reset();
    chk_reg("ctrl1", ADDR_CTRL1, CTRL1_RST);
    chk_reg("ctrl2", ADDR_CTRL2, CTRL2_RST);
    chk_reg("baud hi", ADDR_BAUD_HI, BAUD_RST[15:8]);
    chk_reg("baud lo", ADDR_BAUD_LO, BAUD_RST[7:0]);
    chk_reg("status", ADDR_STATUS, stat(0, 0, 0, 0));
    chk_reg("count", ADDR_COUNT, 8'h00);
    chk_reg("unmapped", 3'h7, 8'h00);
    chk_reg("data empty", ADDR_DATA, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_enable();
    wr_reg(ADDR_BAUD_HI, 8'h00);
    wr_reg(ADDR_BAUD_LO, 8'h00);
    frame(9'h0AA, 1'b0);
    chk_reg("count off", ADDR_COUNT, 8'h00);
    wr_reg(ADDR_CTRL2, 8'h0F);
    chk_reg("ctrl2 on", ADDR_CTRL2, 8'h0F);
    $display("test enable done");
  endtask
  task automatic t_fifo();
    logic [7:0] w [5] = '{8'hA5, 8'h3C, 8'h01, 8'h80, 8'hFF};
    int base;
    base = irq_seen;
    for (int i = 0; i < 5; i++)
      frame({1'b0, w[i]}, 1'b0);
    check_n("irq pulses", base + 2, irq_seen);
    chk_reg("count full", ADDR_COUNT, 8'h04);
    chk_reg("data peek", ADDR_DATA, 8'hA5);
    chk_reg("count kept", ADDR_COUNT, 8'h04);
    for (int i = 0; i < 4; i++)
    begin
      chk_reg("status", ADDR_STATUS, stat(1, i == 0, 0, 0));
      chk_reg("data", ADDR_DATA, w[i]);
    end
    chk_reg("count empty", ADDR_COUNT, 8'h00);
    chk_reg("status empty", ADDR_STATUS, stat(0, 0, 0, 0));
    $display("test fifo done");
  endtask
  task automatic t_idle();
    launch(9'h0C3, 1'b0);
    repeat (40) @(posedge clk);
    chk_reg("status busy", ADDR_STATUS, 8'h00);
    finish_frame();
    chk_reg("status after", ADDR_STATUS, stat(1, 0, 0, 0));
    chk_reg("data", ADDR_DATA, 8'hC3);
    $display("test idle done");
  endtask
  task automatic t_nine();
    wr_reg(ADDR_CTRL1, 8'h02);
    wlen <= 1'b1;
    frame(9'h155, 1'b0);
    chk_reg("ninth bit", ADDR_CTRL1, 8'h03);
    chk_reg("status", ADDR_STATUS, stat(1, 0, 0, 0));
    chk_reg("data", ADDR_DATA, 8'h55);
    wr_reg(ADDR_CTRL1, 8'h04);
    wlen <= 1'b0;
    paren <= 1'b1;
    ptype <= PAR_ODD;
    frame(9'h013, 1'b0);
    chk_reg("parity bad", ADDR_STATUS, stat(1, 0, 0, 1));
    chk_reg("pop", ADDR_COUNT, 8'h01);
    wr_reg(ADDR_STATUS, 8'h00);
    chk_reg("pop data", ADDR_DATA, 8'h13);
    ptype <= PAR_EVEN;
    frame(9'h013, 1'b0);
    chk_reg("parity good", ADDR_STATUS, stat(1, 0, 0, 0));
    chk_reg("pop data", ADDR_DATA, 8'h93);
    paren <= 1'b0;
    wr_reg(ADDR_CTRL1, 8'h00);
    $display("test nine and parity done");
  endtask
  task automatic t_break();
    frame(9'h000, 1'b1);
    chk_reg("break count", ADDR_COUNT, 8'h01);
    chk_reg("break status", ADDR_STATUS, stat(1, 0, 1, 0));
    chk_reg("break data", ADDR_DATA, 8'h00);
    frame(9'h05A, 1'b0);
    chk_reg("next status", ADDR_STATUS, stat(1, 0, 0, 0));
    chk_reg("next data", ADDR_DATA, 8'h5A);
    $display("test break done");
  endtask
  //============================================================
  // main sequence
  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_enable();
    t_fifo();
    t_idle();
    t_nine();
    t_break();
    conclude();
  end
endmodule
